// ==== shared/line_check_pkg.sv ====
// Purpose: Shared constants for the instruction line checker.
// Assumes: One 32-bit slot word per fetch beat, core clock only.
// Notes:   The slot field layout below is the decoder's own.
package line_check_pkg;

  // Line shape
  localparam int          MAX_SLOTS = 4;
  localparam logic [2:0]  LAST_IDX  = 3'h3;

  // Slot word fields
  localparam int EOL_BIT   = 31;
  localparam int CLS_LSB   = 27;
  localparam int SRC_LSB   = 24;
  localparam int DST_LSB   = 21;
  localparam int QUAD_BIT  = 20;
  localparam int PMOD_BIT  = 19;
  localparam int CIRC_BIT  = 18;
  localparam int LONG_BIT  = 17;
  localparam int PTR_LSB   = 11;
  localparam int MOD_LSB   = 0;

  // Slot classes
  localparam logic [3:0] CLS_NOP     = 4'h0;
  localparam logic [3:0] CLS_JALU    = 4'h1;
  localparam logic [3:0] CLS_KALU    = 4'h2;
  localparam logic [3:0] CLS_XFER    = 4'h3;
  localparam logic [3:0] CLS_IMML    = 4'h4;
  localparam logic [3:0] CLS_LDJ     = 4'h5;
  localparam logic [3:0] CLS_LDK     = 4'h6;
  localparam logic [3:0] CLS_STJ     = 4'h7;
  localparam logic [3:0] CLS_STK     = 4'h8;
  localparam logic [3:0] CLS_IMMEXT  = 4'h9;
  localparam logic [3:0] CLS_COND    = 4'hA;
  localparam logic [3:0] CLS_CONDSEQ = 4'hB;
  localparam logic [3:0] CLS_COMPX   = 4'hC;
  localparam logic [3:0] CLS_COMPY   = 4'hD;

  // Register groups named by source and destination fields
  localparam logic [2:0] GRP_NONE = 3'h0;
  localparam logic [2:0] GRP_J    = 3'h1;
  localparam logic [2:0] GRP_K    = 3'h2;
  localparam logic [2:0] GRP_X    = 3'h3;
  localparam logic [2:0] GRP_Y    = 3'h4;
  localparam logic [2:0] GRP_XY   = 3'h5;
  localparam logic [2:0] GRP_SEQ  = 3'h6;
  localparam logic [2:0] GRP_SOC  = 3'h7;

  // Resource indices
  localparam int NRES   = 15;
  localparam int R_AUNIT = 0;
  localparam int R_JU   = 1;
  localparam int R_KU   = 2;
  localparam int R_JPT  = 3;
  localparam int R_KPT  = 4;
  localparam int R_XIO  = 5;
  localparam int R_XIN  = 6;
  localparam int R_XOUT = 7;
  localparam int R_YIO  = 8;
  localparam int R_YIN  = 9;
  localparam int R_YOUT = 10;
  localparam int R_SEQ  = 11;
  localparam int R_SOC  = 12;
  localparam int R_XCB  = 13;
  localparam int R_YCB  = 14;

  // Units available per line, index 14 down to 0
  localparam logic [3*NRES-1:0] RES_LIMIT = {
    3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1,
    3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2};

  // Checker states
  typedef enum logic [2:0] {
    ST_FILL  = 3'h1,
    ST_CHECK = 3'h2,
    ST_ISSUE = 3'h4
  } line_state_t;

endpackage : line_check_pkg

// ==== design/slot_cost.sv ====
// Purpose: Per-slot decode of resource use and single-slot legality.
// Assumes: Word layout from line_check_pkg.
// Notes:   Pure combinational; one instance per slot position.
`timescale 1ns/1ns
module slot_cost
  import line_check_pkg::*;
(
  // Slot input
  input  wire logic [31:0]     word,
  input  wire logic [1:0]      slot_idx,
  // Decode results
  output logic [2*NRES-1:0]    cost,
  output logic [3:0]           rd_grp,
  output logic [3:0]           wr_grp,
  output logic                 slot_bad
);

  wire logic [3:0] cls  = word[CLS_LSB +: 4];
  wire logic [2:0] src  = word[SRC_LSB +: 3];
  wire logic [2:0] dst  = word[DST_LSB +: 3];
  wire logic [4:0] ptr  = word[PTR_LSB +: 5];
  wire logic [7:0] modv = word[MOD_LSB +: 8];

  wire logic is_ldj  = (cls == CLS_LDJ);
  wire logic is_ldk  = (cls == CLS_LDK);
  wire logic is_stj  = (cls == CLS_STJ);
  wire logic is_stk  = (cls == CLS_STK);
  wire logic is_mem  = is_ldj | is_ldk | is_stj | is_stk;
  wire logic use_src = (cls == CLS_XFER) | is_stj | is_stk;
  wire logic use_dst = (cls == CLS_XFER) | (cls == CLS_IMML) | is_ldj | is_ldk;
  wire logic is_cond = (cls == CLS_COND) | (cls == CLS_CONDSEQ);

  // Group bitmask: bit0 X, bit1 Y, bit2 J, bit3 K
  function automatic logic [3:0] grp_mask(input logic [2:0] g);
    grp_mask = {g == GRP_K, g == GRP_J, (g == GRP_Y) | (g == GRP_XY),
                (g == GRP_X) | (g == GRP_XY)};
  endfunction : grp_mask

  // Base plus source plus destination cost of one slot
  always_comb begin
    logic [1:0] c [NRES];
    for (int r = 0; r < NRES; r++) begin
      c[r] = 2'h0;
    end
    // Base cost by move or arithmetic type
    if ((cls == CLS_JALU) | is_ldj | is_stj) begin
      c[R_AUNIT] = 2'h1;
      c[R_JU]    = 2'h1;
    end
    if ((cls == CLS_KALU) | is_ldk | is_stk) begin
      c[R_AUNIT] = 2'h1;
      c[R_KU]    = 2'h1;
    end
    if ((cls == CLS_XFER) | (cls == CLS_IMML)) begin
      c[R_AUNIT] = 2'h1;
    end
    if (cls == CLS_COMPX) c[R_XCB] = 2'h1;
    if (cls == CLS_COMPY) c[R_YCB] = 2'h1;
    // Post-modified pointer writes back through its unit port
    if (is_mem && word[PMOD_BIT]) begin
      if (is_ldj | is_stj) c[R_JPT] = 2'h1;
      else                 c[R_KPT] = 2'h1;
    end
    // Source register charged only when source is a register
    if (use_src) begin
      if (src == GRP_J) c[R_JPT] = c[R_JPT] + 2'h1;
      if (src == GRP_K) c[R_KPT] = c[R_KPT] + 2'h1;
      if (src == GRP_X || src == GRP_XY) begin
        c[R_XIO]  = c[R_XIO] + 2'h1;
        c[R_XOUT] = c[R_XOUT] + 2'h1;
      end
      if (src == GRP_Y || src == GRP_XY) begin
        c[R_YIO]  = c[R_YIO] + 2'h1;
        c[R_YOUT] = c[R_YOUT] + 2'h1;
      end
      if (src == GRP_SEQ) c[R_SEQ] = 2'h1;
      if (src == GRP_SOC) c[R_SOC] = 2'h1;
    end
    // Destination register charges
    if (use_dst) begin
      if (dst == GRP_J) c[R_JPT] = c[R_JPT] + 2'h1;
      if (dst == GRP_K) c[R_KPT] = c[R_KPT] + 2'h1;
      if (dst == GRP_X || dst == GRP_XY) begin
        c[R_XIO] = c[R_XIO] + 2'h1;
        c[R_XIN] = c[R_XIN] + 2'h1;
      end
      if (dst == GRP_Y || dst == GRP_XY) begin
        c[R_YIO] = c[R_YIO] + 2'h1;
        c[R_YIN] = c[R_YIN] + 2'h1;
      end
      if (dst == GRP_SEQ) c[R_SEQ] = c[R_SEQ] + 2'h1;
      if (dst == GRP_SOC) c[R_SOC] = c[R_SOC] + 2'h1;
    end
    for (int r = 0; r < NRES; r++) begin
      cost[2*r +: 2] = c[r];
    end
  end

  // Register groups read and written, for the operand hazard
  assign rd_grp = (use_src ? grp_mask(src) : 4'h0) |
                  ((cls == CLS_COMPX) ? 4'h1 : 4'h0) | ((cls == CLS_COMPY) ? 4'h2 : 4'h0);
  assign wr_grp = (use_dst ? grp_mask(dst) : 4'h0) |
                  ((cls == CLS_COMPX) ? 4'h1 : 4'h0) | ((cls == CLS_COMPY) ? 4'h2 : 4'h0);

  // Single-slot legality: placement, quad modifier, circular pointer
  assign slot_bad = ((cls == CLS_IMMEXT) && (slot_idx != 2'h1))
                  | (is_cond && (slot_idx != 2'h0))
                  | (is_mem && word[QUAD_BIT] && word[PMOD_BIT] && |modv[1:0])
                  | (is_mem && word[CIRC_BIT] && |ptr[4:2]);

endmodule : slot_cost

// ==== design/instruction_line_parallelism_checker.sv ====
// Purpose: Gathers slot words into lines, checks them, issues whole lines.
// Assumes: One slot word per cycle from fetch; execution answers same cycle.
// Notes:   Execution options travel in the words untouched; no mode bits here.
// Overview of operation
// - Lines of one to four 32-bit slots issue together in one cycle.
// - Word MSB marks a line's last slot; next word starts a new line.
// - Whole line stalls or executes as one unit.
// - First slot condition enables or suppresses the remaining slots.
// - Two forms: condition guards three slots, or sequencer op plus else slots.
// - Immediate extension only in slot two; condition only in slot one.
// - Every execution option comes from the encoding, no control mode bits.
// - Resource checks span one line only, never successive lines.
// - Stall while a slot needs a previous-line result not yet ready.
// - Sum resource units over the line; any excess makes it illegal.
// - Move cost is base plus register source plus destination costs.
// - Offsets wider than eight bits need the extension in slot two.
// - Runtime violations raise an exception; the line never deadlocks.
// - Quad post-modify not multiple of four illegal; misaligned pointer traps.
// - Circular accesses only via pointers zero to three of each unit.
// - Jump register to both files uses slot, address unit, sequencer, input ports.
// - Four first-unit registers to both files use input and output ports.
`timescale 1ns/1ns
module instruction_line_parallelism_checker
  import line_check_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Fetch side
  input  wire logic [31:0]  in_word,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Execution side
  input  wire logic         issue_ready,
  input  wire logic         operand_ready,
  input  wire logic         cond_true,
  input  wire logic [3:0]   quad_misaligned,
  output logic              issue_valid,
  output logic [127:0]      issue_line,
  output logic [2:0]        issue_count,
  output logic [3:0]        exec_en,
  output logic [7:0]        cond_code,
  // Exceptions
  output logic              illegal_line,
  output logic              runtime_exc
);

  line_state_t       state_r, state_nxt;
  logic [31:0]       slot_r [MAX_SLOTS];
  logic [2:0]        count_r;
  logic [3:0]        prev_wr_r;
  logic              bad_r;
  logic              illegal_r;
  logic              exc_r;

  logic [2*NRES-1:0] cost [MAX_SLOTS];
  logic [3:0]        rd_grp [MAX_SLOTS];
  logic [3:0]        wr_grp [MAX_SLOTS];
  logic [3:0]        slot_bad;
  logic [3:0]        used;
  logic [3:0]        line_rd, line_wr;
  logic [NRES-1:0]   over;

  // Per-slot decoders
  for (genvar s = 0; s < MAX_SLOTS; s++) begin : g_slot
    assign used[s] = (3'(s) < count_r);
    slot_cost u_cost (
      .word     (slot_r[s]),
      .slot_idx (2'(s)),
      .cost     (cost[s]),
      .rd_grp   (rd_grp[s]),
      .wr_grp   (wr_grp[s]),
      .slot_bad (slot_bad[s])
    );
  end

  // Totals over the present line only; nothing carries from older lines
  always_comb begin
    logic [3:0] tot;
    tot     = 4'h0;
    line_rd = 4'h0;
    line_wr = 4'h0;
    for (int r = 0; r < NRES; r++) begin
      tot = 4'h0; // Four bits: four slots at three units each would wrap three
      for (int s = 0; s < MAX_SLOTS; s++) begin
        if (used[s]) tot = tot + {2'h0, cost[s][2*r +: 2]};
      end
      over[r] = (tot > {1'h0, RES_LIMIT[3*r +: 3]});
    end
    for (int s = 0; s < MAX_SLOTS; s++) begin
      if (used[s]) begin
        line_rd = line_rd | rd_grp[s];
        line_wr = line_wr | wr_grp[s];
      end
    end
  end

  // Field views of the first two slots
  wire logic [3:0] cls0   = slot_r[0][CLS_LSB +: 4];
  wire logic [3:0] cls1   = slot_r[1][CLS_LSB +: 4];
  wire logic       mem0   = (cls0 >= CLS_LDJ) && (cls0 <= CLS_STK);
  wire logic       imml0  = (cls0 == CLS_IMML) || (cls0 == CLS_JALU) || (cls0 == CLS_KALU);
  wire logic       long0  = (mem0 || imml0) && slot_r[0][LONG_BIT];
  wire logic       ext1   = used[1] && (cls1 == CLS_IMMEXT);
  wire logic       ext_ok = (long0 == ext1);

  // Long offsets sitting in later slots cannot own slot two
  logic [3:0] late_long;
  for (genvar s = 1; s < MAX_SLOTS; s++) begin : g_long
    assign late_long[s] = used[s] && slot_r[s][LONG_BIT] &&
                          (slot_r[s][CLS_LSB +: 4] >= CLS_JALU) &&
                          (slot_r[s][CLS_LSB +: 4] <= CLS_STK) &&
                          (slot_r[s][CLS_LSB +: 4] != CLS_XFER);
  end
  assign late_long[0] = 1'b0;

  wire logic line_bad = (|(slot_bad & used)) || (|over) || !ext_ok || (|late_long);

  // Operand hazard against the line just before; an illegal line counts as writing nothing
  wire logic hazard = (|(line_rd & prev_wr_r)) && !operand_ready;

  // Handshakes
  assign in_ready    = (state_r == ST_FILL);
  wire logic accept  = in_ready && in_valid;
  wire logic line_end = accept && (in_word[EOL_BIT] || (count_r == LAST_IDX));
  assign issue_valid = (state_r == ST_ISSUE) && issue_ready && !hazard && !bad_r;

  // Predication: slot one holds the condition, the rest follow it
  wire logic do_form   = (cls0 == CLS_COND);
  wire logic else_form = (cls0 == CLS_CONDSEQ);
  wire logic rest_en   = do_form ? cond_true : (else_form ? !cond_true : 1'b1);
  assign exec_en     = issue_valid ? (used & {rest_en, rest_en, rest_en, 1'b1}) : 4'h0;
  assign cond_code   = slot_r[0][MOD_LSB +: 8];

  // Issued data straight from the slot flops; options pass unaltered
  for (genvar s = 0; s < MAX_SLOTS; s++) begin : g_out
    assign issue_line[32*s +: 32] = slot_r[s];
  end
  assign issue_count  = count_r;
  assign illegal_line = illegal_r;
  assign runtime_exc  = exc_r;

  // Line sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_FILL:  if (line_end) state_nxt = ST_CHECK;
      ST_CHECK: state_nxt = line_bad ? ST_FILL : ST_ISSUE;
      ST_ISSUE: if (issue_valid) state_nxt = ST_FILL;
      default:  state_nxt = ST_FILL;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) state_r <= ST_FILL;
    else       state_r <= state_nxt;
  end

  // Slot capture and line length
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_r <= 3'h0;
      for (int s = 0; s < MAX_SLOTS; s++) slot_r[s] <= 32'h0000_0000;
    end else if (accept) begin
      slot_r[count_r[1:0]] <= in_word;
      count_r <= count_r + 3'h1;
    end else if ((state_r == ST_CHECK && line_bad) || issue_valid) begin
      count_r <= 3'h0;
    end
  end

  // Check verdict, exceptions and written groups of the issued line
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bad_r     <= 1'b0;
      illegal_r <= 1'b0;
      exc_r     <= 1'b0;
      prev_wr_r <= 4'h0;
    end else begin
      bad_r     <= (state_r == ST_CHECK) ? line_bad : (bad_r && state_r != ST_FILL);
      illegal_r <= (state_r == ST_CHECK) && line_bad;
      exc_r     <= issue_valid && (|(quad_misaligned & used));
      if (issue_valid) prev_wr_r <= line_wr;
      else if (state_r == ST_CHECK && line_bad) prev_wr_r <= 4'h0;
    end
  end

  // Checks on the design's own behaviour
  AST_ISSUE_STATE: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid |-> (state_r == ST_ISSUE) && (count_r != 3'h0) && (count_r <= 3'h4))
    else $error("issue outside a checked line");
  AST_LINE_END: assert property (@(posedge ref_clk) disable iff (reset)
    accept && in_word[EOL_BIT] |=> state_r == ST_CHECK && !in_ready)
    else $error("line end bit did not close the line");
  AST_STALL_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == ST_ISSUE && !issue_ready |=> state_r == ST_ISSUE && $stable(issue_line))
    else $error("stalled line changed");
  AST_PRED_DO: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && do_form && !cond_true |-> exec_en == 4'h1)
    else $error("guarded slots ran on false condition");
  AST_PRED_ELSE: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && else_form && cond_true |-> exec_en == 4'h1)
    else $error("else slots ran on true condition");
  AST_ILLEGAL: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == ST_CHECK && line_bad |=> illegal_line && !issue_valid ##1 !illegal_line)
    else $error("illegal line not flagged once");
  AST_HAZARD: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == ST_ISSUE && (|(line_rd & prev_wr_r)) && !operand_ready |-> !issue_valid)
    else $error("line issued over pending operand");
  AST_RUNTIME: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && (|(quad_misaligned & used)) |=> runtime_exc && state_r == ST_FILL)
    else $error("misaligned quad not trapped");
  AST_CHECK_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state_r == ST_ISSUE) |-> $past(state_r) == ST_CHECK && !bad_r)
    else $error("issue reached without a clean check");

endmodule : instruction_line_parallelism_checker

// ==== verif/exec_partner.sv ====
// Purpose: Execution side stand-in for the line checker's issue port.
// Assumes: Bench steers busy time, operand hold, condition and alignment.
// Notes:   Busy time after each issue lets the bench play a slow taker.
`timescale 1ns/1ns
module exec_partner (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // From the checker
  input  wire logic        issue_valid,
  // Bench knobs
  input  wire logic [3:0]  busy_len,
  input  wire logic        hold_ops,
  input  wire logic        cond_val,
  input  wire logic [3:0]  misalign,
  // To the checker
  output logic             issue_ready,
  output logic             operand_ready,
  output logic             cond_true,
  output logic [3:0]       quad_misaligned
);
  logic [3:0] busy_r;

  // Countdown after each taken line; a slow unit refuses until it drains
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_r <= 4'h0;
    end else if (issue_valid && issue_ready) begin
      busy_r <= busy_len;
    end else if (busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
  end

  // Answers; the condition stays level so no loop forms through issue_valid
  assign issue_ready     = (busy_r == 4'h0);
  assign operand_ready   = !hold_ops;
  assign cond_true       = cond_val;
  assign quad_misaligned = misalign;
endmodule : exec_partner

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the instruction line checker.
// Assumes: exec_partner plays the execution units; the bench plays fetch.
// Notes:   Verdicts are read at clock edges, so pre-edge values are seen.
`timescale 1ns/1ns
module testbench
  import line_check_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         reset = 1'b1;
  logic [31:0]  in_word = 32'h0;
  logic         in_valid = 1'b0;
  logic [3:0]   busy_len = 4'h0;
  logic         hold_ops = 1'b0;
  logic         cond_val = 1'b0;
  logic [3:0]   misalign = 4'h0;
  logic         in_ready, issue_ready, operand_ready, cond_true;
  logic         issue_valid, illegal_line, runtime_exc;
  logic [3:0]   quad_misaligned, exec_en, got_en;
  logic [127:0] issue_line, got_line;
  logic [2:0]   issue_count, got_cnt;
  logic [7:0]   cond_code, got_cc;
  logic         got_iss, got_ill, got_exc;
  int           n_fail = 0;
  int           check_count = 0;
  int           cyc = 0;
  int           lat;

  always #5 ref_clk = ~ref_clk;

  instruction_line_parallelism_checker dut (.ref_clk, .reset, .in_word, .in_valid,
    .in_ready, .issue_ready, .operand_ready, .cond_true, .quad_misaligned, .issue_valid,
    .issue_line, .issue_count, .exec_en, .cond_code, .illegal_line, .runtime_exc);
  exec_partner partner (.ref_clk, .reset, .issue_valid, .busy_len, .hold_ops, .cond_val,
    .misalign, .issue_ready, .operand_ready, .cond_true, .quad_misaligned);

  // Slot word: class, source, destination, {quad,postmod,circ,long}, pointer, modifier
  function automatic logic [31:0] w(input logic [3:0] c, input logic [2:0] s,
      input logic [2:0] d, input logic [3:0] f, input logic [4:0] p, input logic [7:0] m);
    return {1'b0, c, s, d, f, 1'b0, p, 3'h0, m};
  endfunction : w

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // Sends one line, end mark on the last word, then waits for the verdict
  task automatic run_line(input logic [127:0] ws, input int n);
    int k;
    int t;
    got_iss = 1'b0;
    got_ill = 1'b0;
    got_exc = 1'b0;
    for (k = 0; k < n; k++) begin
      in_valid <= 1'b1;
      in_word <= ws[32*k +: 32] | ((k == n - 1) ? 32'h8000_0000 : 32'h0);
      t = 0;
      do begin
        @(posedge ref_clk);
        t++;
      end while (in_ready !== 1'b1 && t < 50);
    end
    in_valid <= 1'b0;
    for (t = 0; t < 60 && !got_iss && !got_ill; t++) begin
      @(posedge ref_clk);
      lat = t + 1;
      got_ill = (illegal_line === 1'b1);
      got_iss = (issue_valid === 1'b1);
      got_en = exec_en;
      got_cnt = issue_count;
      got_line = issue_line;
      got_cc = cond_code;
    end
    if (got_iss) begin
      @(posedge ref_clk);
      got_exc = (runtime_exc === 1'b1);
    end
    @(posedge ref_clk);
  endtask : run_line

  task automatic expect_ok(input logic [127:0] ws, input int n, input logic ok);
    run_line(ws, n);
    chk(got_iss, ok);
    chk(got_ill, !ok);
  endtask : expect_ok

  // Lines of one to four slots; words must reach the issue side untouched
  task automatic t_shapes();
    logic [127:0] ws;
    int n;
    ws = {32'h0000_005C, 32'h0000_00C3, 32'h0000_0011, 32'h0000_00B2};
    for (n = 1; n <= 4; n++) begin
      run_line(ws, n);
      chk(got_iss, 1'b1);
      chk(got_cnt, n[2:0]);
      chk(got_en, (32'h1 << n) - 32'h1);
      chk(got_line[32*(n-1) +: 32], ws[32*(n-1) +: 32] | 32'h8000_0000);
      chk(got_cc, ws[7:0]);
    end
    $display("test shapes done");
  endtask : t_shapes

  // Both predicated forms against both condition outcomes
  task automatic t_cond();
    int k;
    for (k = 0; k < 4; k++) begin
      cond_val <= k[0];
      run_line({96'h0, w(k[1] ? CLS_CONDSEQ : CLS_COND, 3'h0, 3'h0, 4'h0, 5'h0, 8'h21)}, 4);
      chk(got_cc, 8'h21);
      chk(got_en, (k[1] ^ k[0]) ? 32'hF : 32'h1);
      chk(got_iss, 1'b1);
    end
    cond_val <= 1'b0;
    $display("test cond done");
  endtask : t_cond

  // Slot placement of conditions and extensions, long offsets
  task automatic t_place();
    logic [31:0] ext;
    logic [31:0] lng;
    ext = w(CLS_IMMEXT, 3'h0, 3'h0, 4'h0, 5'h0, 8'h00);
    lng = w(CLS_LDJ, 3'h0, GRP_X, 4'h1, 5'h0, 8'h40);
    expect_ok({64'h0, w(CLS_COND, 3'h0, 3'h0, 4'h0, 5'h0, 8'h0), 32'h0}, 2, 1'b0);
    expect_ok({96'h0, ext}, 1, 1'b0);
    expect_ok({64'h0, ext, 32'h0}, 2, 1'b0);
    expect_ok({64'h0, ext, lng}, 2, 1'b1);
    expect_ok({96'h0, lng}, 1, 1'b0);
    expect_ok({64'h0, lng, 32'h0}, 2, 1'b0);
    $display("test place done");
  endtask : t_place

  // Resource sums within a line, none across lines
  task automatic t_res();
    logic [31:0] ja;
    logic [31:0] sq;
    logic [31:0] jx;
    logic [31:0] ld;
    ja = w(CLS_JALU, 3'h0, 3'h0, 4'h0, 5'h0, 8'h05);
    sq = w(CLS_XFER, GRP_SEQ, GRP_XY, 4'h0, 5'h0, 8'h0);
    jx = w(CLS_XFER, GRP_J, GRP_XY, 4'h0, 5'h0, 8'h0);
    ld = w(CLS_LDJ, 3'h0, GRP_X, 4'h4, 5'h0, 8'h01);
    expect_ok({64'h0, ja, ja}, 2, 1'b0);
    expect_ok({96'h0, ja}, 1, 1'b1);
    expect_ok({96'h0, ja}, 1, 1'b1);
    expect_ok({96'h0, sq}, 1, 1'b1);
    expect_ok({64'h0, sq, sq}, 2, 1'b0);
    expect_ok({96'h0, jx}, 1, 1'b1);
    expect_ok({64'h0, jx, jx}, 2, 1'b0);
    expect_ok({96'h0, ld}, 1, 1'b1);
    expect_ok({64'h0, w(CLS_XFER, GRP_J, GRP_K, 4'h0, 5'h0, 8'h0), ld}, 2, 1'b0);
    $display("test resources done");
  endtask : t_res

  // Quad modifier legality and misaligned pointer trap; circular pointers
  task automatic t_quad_circ();
    expect_ok({96'h0, w(CLS_LDJ, 3'h0, GRP_X, 4'hC, 5'h0, 8'h03)}, 1, 1'b0);
    misalign <= 4'h1;
    expect_ok({96'h0, w(CLS_LDJ, 3'h0, GRP_X, 4'hC, 5'h0, 8'h04)}, 1, 1'b1);
    chk(got_exc, 1'b1);
    misalign <= 4'hE;
    expect_ok({96'h0, w(CLS_LDJ, 3'h0, GRP_X, 4'hC, 5'h0, 8'h04)}, 1, 1'b1);
    chk(got_exc, 1'b0);
    misalign <= 4'h0;
    expect_ok({96'h0, w(CLS_LDJ, 3'h0, GRP_X, 4'h2, 5'h04, 8'h01)}, 1, 1'b0);
    expect_ok({96'h0, w(CLS_LDJ, 3'h0, GRP_X, 4'h2, 5'h03, 8'h01)}, 1, 1'b1);
    expect_ok({96'h0, w(CLS_LDK, 3'h0, GRP_X, 4'h2, 5'h1F, 8'h01)}, 1, 1'b0);
    $display("test quad and circular done");
  endtask : t_quad_circ

  // Operand hazard and slow execution units both hold the whole line
  task automatic t_stall();
    logic [31:0] wr;
    logic [31:0] ja;
    wr = w(CLS_XFER, GRP_X, GRP_J, 4'h0, 5'h0, 8'h0);
    ja = w(CLS_JALU, 3'h0, 3'h0, 4'h0, 5'h0, 8'h05);
    run_line({96'h0, wr}, 1);
    hold_ops <= 1'b1;
    run_line({96'h0, ja}, 1);
    chk(lat, 2);
    hold_ops <= 1'b0;
    run_line({96'h0, wr}, 1);
    hold_ops <= 1'b1;
    fork
      begin
        repeat (8) @(posedge ref_clk);
        hold_ops <= 1'b0;
      end
    join_none
    run_line({96'h0, w(CLS_XFER, GRP_J, GRP_X, 4'h0, 5'h0, 8'h0), ja}, 2);
    chk(got_iss, 1'b1);
    chk(lat >= 6, 1'b1);
    chk(got_en, 32'h3);
    busy_len <= 4'h6;
    run_line({96'h0, ja}, 1);
    busy_len <= 4'h0;
    run_line({96'h0, ja}, 1);
    chk(lat > 2, 1'b1);
    chk(got_iss, 1'b1);
    $display("test stall done");
  endtask : t_stall

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Main sequence: reset held ten cycles, idle outputs checked inside it
  initial begin
    repeat (10) @(posedge ref_clk);
    chk({in_ready, issue_valid, exec_en, illegal_line, runtime_exc}, 32'h80);
    chk({21'h0, issue_count, cond_code}, 32'h0);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_shapes();
    t_cond();
    t_place();
    t_res();
    t_quad_circ();
    t_stall();
    report_and_stop();
  end
endmodule : testbench
